// ---- bench/mcp_host.sv ----
/*
  Host model of the register bus: one write or read at a time.
  Assumes its tasks are entered just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mcp_host (
  input  wire logic        clk,
  output var  logic [7:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [7:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  logic hung;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hung} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awaddr <= ~a;
      if (awready) awvalid <= 1'b0;
      // Released data flips so a stale word never looks valid
      if (wready) wdata <= ~d;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    // Ready stays high, so back-to-back calls never retoggle it
    r = bresp;
    if (n >= 50) hung = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) araddr <= ~a;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50) hung = 1'b1;
  endtask
endmodule // mcp_host
`default_nettype wire

// ---- bench/mcp_precheck_props.sv ----
/*
  Checker of the precheck go and refuse pulses.
  Assumes binding to mcp_precheck, one clock, state inputs held steady.
*/
`timescale 1ns/1ps
`default_nettype none
module mcp_precheck_props (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] axis_busy,
  input  wire logic [1:0] out_inhibit,
  input  wire logic [1:0] speed_ctrl,
  input  wire logic [1:0] sync_sub,
  input  wire logic       circ_go,
  input  wire logic       simul_go,
  input  wire logic       spd2pos_go,
  input  wire logic       pos2spd_go,
  input  wire logic [1:0] cmd_axis,
  input  wire logic       cmd_reject,
  input  wire logic [1:0] aux_code_clear_cmd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [1:0] sel;
  // Switching commands name one axis by bit 5
  assign sel = cmd_axis[1] ? 2'h2 : 2'h1;
  chk_rej_no_go: assert property (cmd_reject |-> !(circ_go || simul_go || spd2pos_go || pos2spd_go))
    else $error("go pulse beside a refusal");
  chk_rej_pulse: assert property (cmd_reject |=> !cmd_reject)
    else $error("refusal pulse too long");
  chk_clr_pulse: assert property (|aux_code_clear_cmd |=> aux_code_clear_cmd == 2'h0)
    else $error("clear pulse too long");
  chk_go_onehot: assert property ($onehot0({circ_go, simul_go, spd2pos_go, pos2spd_go, cmd_reject}))
    else $error("two outcomes at once");
  chk_circ_inh: assert property (circ_go |-> $past(out_inhibit) == 2'h0)
    else $error("arc started while inhibited");
  chk_simul_ok: assert property (simul_go |-> $past(axis_busy | out_inhibit) == 2'h0 && cmd_axis == 2'h3)
    else $error("simultaneous start on a bad axis");
  chk_s2p_state: assert property (spd2pos_go |-> ($past(axis_busy & speed_ctrl & ~sync_sub) & sel) != 2'h0)
    else $error("speed to position on a bad axis");
  chk_p2s_state: assert property (pos2spd_go |-> ($past(axis_busy & ~sync_sub) & sel) != 2'h0)
    else $error("position to speed on a bad axis");
  cover property (cmd_reject);
  cover property (circ_go);
  cover property (pos2spd_go);
endmodule // mcp_precheck_props

bind mcp_precheck mcp_precheck_props u_mcp_precheck_props (.clk(clk), .nrst(nrst), .axis_busy(axis_busy),
  .out_inhibit(out_inhibit), .speed_ctrl(speed_ctrl), .sync_sub(sync_sub), .circ_go(circ_go),
  .simul_go(simul_go), .spd2pos_go(spd2pos_go), .pos2spd_go(pos2spd_go), .cmd_axis(cmd_axis),
  .cmd_reject(cmd_reject), .aux_code_clear_cmd(aux_code_clear_cmd));
`default_nettype wire

// ---- bench/mcp_precheck_test.sv ----
/*
  Bench of the motion command precheck: host model on the bus, axis
  state driven here. Assumes a 40 MHz clock and the design's map.
*/
`timescale 1ns/1ps
`default_nettype none
module mcp_precheck_test;
  logic        clk, nrst, awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic        c_go, s_go, sp_go, ps_go, rej;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdt, px, py, d;
  logic [3:0]  ws;
  logic [1:0]  bre, rre, busy, inh, spd, sub, aux, home, r, cax, clr;
  int          n_mismatch, compares, n_go, n_rej;
  logic [1:0]  clr_seen = 2'h0;
  mcp_host u_mcp_host (.clk(clk), .awaddr(awa), .awvalid(awv), .awready(awr), .wdata(wd), .wstrb(ws),
    .wvalid(wv), .wready(wr_r), .bresp(bre), .bvalid(bv), .bready(br), .araddr(ara), .arvalid(arv),
    .arready(arr), .rdata(rdt), .rresp(rre), .rvalid(rv), .rready(rr));
  mcp_precheck u_mcp_precheck (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .axis_busy(busy), .out_inhibit(inh), .speed_ctrl(spd), .sync_sub(sub), .aux_code_on(aux),
    .homing_done(home), .cur_pos_x(px), .cur_pos_y(py), .circ_go(c_go), .simul_go(s_go),
    .spd2pos_go(sp_go), .pos2spd_go(ps_go), .cmd_axis(cax), .cmd_reject(rej), .aux_code_clear_cmd(clr));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if ((c_go | s_go | sp_go | ps_go) === 1'b1) n_go++;
  always @(posedge clk) if (rej === 1'b1) n_rej++;
  always @(posedge clk) if (clr !== 2'h0) clr_seen <= clr;
  task automatic summarize();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic hc();
    if (u_mcp_host.hung) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_mcp_host.wr(a, v, r);
    hc();
    cmp({30'h0, r}, 32'h0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    u_mcp_host.rd(a, d, r);
    hc();
    cmp(d, e);
  endtask
  // Error word is cleared after each check so the next one starts clean
  task automatic cmd(input logic [7:0] c, input logic [7:0] ea, input logic [15:0] e, input int g);
    int g0, j0;
    g0 = n_go;
    j0 = n_rej;
    wr(8'h00, {24'h0, c});
    repeat (3) @(posedge clk);
    rc(ea, {16'h0, e});
    cmp(n_go - g0, g);
    cmp(n_rej - j0, 1 - g);
    cmp({30'h0, cax}, {30'h0, c[5:4]});
    wr(ea, 32'h0);
  endtask
  task automatic pl(input logic [1:0] a, input logic [1:0] h);
    aux <= a;
    home <= h;
    @(posedge clk);
    aux <= 2'h0;
    home <= 2'h0;
  endtask
  initial begin
    {nrst, busy, inh, spd, sub, aux, home, px, py} <= '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rc(8'h20, 32'h0);
    rc(8'h24, 32'h0);
    u_mcp_host.rd(8'h40, d, r);
    cmp({30'h0, r}, 32'h2);
    cmp(d, 32'h0);
    u_mcp_host.wr(8'h20, 32'hFF, r);
    cmp({30'h0, r}, 32'h2);
    wr(8'h04, 32'h0);
    wr(8'h08, 32'hA);
    wr(8'h10, 32'h5);
    wr(8'h18, 32'h5);
    wr(8'h1C, 32'h1);
    inh <= 2'h2;
    cmd(8'h01, 8'h28, 16'h0112, 0);
    inh <= 2'h0;
    pl(2'h1, 2'h0);
    cmd(8'h01, 8'h24, 16'h0113, 0);
    wr(8'h00, 32'h15);
    cmd(8'h01, 8'h24, 16'h0000, 1);
    cmp({30'h0, clr_seen}, 32'h1);
    pl(2'h2, 2'h0);
    cmd(8'h01, 8'h28, 16'h0114, 0);
    wr(8'h00, 32'h25);
    wr(8'h04, 32'h1);
    cmd(8'h01, 8'h24, 16'h0115, 0);
    cmp({30'h0, clr_seen}, 32'h2);
    rc(8'h20, 32'h20);
    pl(2'h0, 2'h1);
    cmd(8'h01, 8'h28, 16'h0116, 0);
    wr(8'h00, 32'h26);
    cmd(8'h01, 8'h24, 16'h0000, 1);
    rc(8'h20, 32'h3);
    wr(8'h04, 32'h0);
    wr(8'h10, 32'h0);
    cmd(8'h01, 8'h24, 16'h011C, 0);
    wr(8'h10, 32'hA);
    cmd(8'h01, 8'h24, 16'h011C, 0);
    wr(8'h10, 32'h5);
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h0);
    cmd(8'h01, 8'h24, 16'h011D, 0);
    wr(8'h08, 32'hA);
    wr(8'h18, 32'h1);
    cmd(8'h01, 8'h24, 16'h011F, 0);
    wr(8'h04, 32'h0);
    cmd(8'h01, 8'h24, 16'h0000, 1);
    wr(8'h18, 32'h0);
    cmd(8'h01, 8'h24, 16'h011E, 0);
    wr(8'h18, 32'h80000000);
    cmd(8'h01, 8'h24, 16'h011E, 0);
    wr(8'h18, 32'h5);
    wr(8'h1C, 32'h64);
    cmd(8'h01, 8'h24, 16'h0122, 0);
    busy <= 2'h1;
    cmd(8'h32, 8'h24, 16'h0123, 0);
    busy <= 2'h0;
    inh <= 2'h2;
    cmd(8'h32, 8'h28, 16'h0124, 0);
    inh <= 2'h0;
    pl(2'h2, 2'h0);
    cmd(8'h32, 8'h28, 16'h0125, 0);
    wr(8'h00, 32'h25);
    cmd(8'h32, 8'h28, 16'h0126, 0);
    wr(8'h0C, 32'h3);
    wr(8'h04, 32'h1);
    px <= 32'hA;
    cmd(8'h32, 8'h24, 16'h0126, 0);
    px <= 32'h0;
    cmd(8'h32, 8'h24, 16'h0000, 1);
    cmd(8'h12, 8'h24, 16'h0128, 0);
    cmd(8'h22, 8'h24, 16'h0128, 0);
    cmd(8'h03, 8'h24, 16'h012D, 0);
    busy <= 2'h1;
    cmd(8'h03, 8'h24, 16'h012E, 0);
    spd <= 2'h1;
    sub <= 2'h1;
    cmd(8'h03, 8'h24, 16'h012F, 0);
    sub <= 2'h0;
    wr(8'h08, 32'h0);
    cmd(8'h03, 8'h24, 16'h0130, 0);
    wr(8'h08, 32'hA);
    cmd(8'h03, 8'h24, 16'h0000, 1);
    cmd(8'h24, 8'h28, 16'h0137, 0);
    busy <= 2'h3;
    sub <= 2'h2;
    cmd(8'h24, 8'h28, 16'h0138, 0);
    sub <= 2'h0;
    cmd(8'h24, 8'h28, 16'h0000, 1);
    summarize();
  end
endmodule // mcp_precheck_test
`default_nettype wire

// ---- include/mcp_cfg.svh ----
/*
  Constants of the motion command precheck: register offsets, field
  positions, reset values and error codes. Definitions only.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef MCP_CFG_SVH
`define MCP_CFG_SVH

`define MCP_A_CMD     6'h00
`define MCP_A_CFG     6'h01
`define MCP_A_GOAL_X  6'h02
`define MCP_A_GOAL_Y  6'h03
`define MCP_A_AUXP_X  6'h04
`define MCP_A_AUXP_Y  6'h05
`define MCP_A_RADIUS  6'h06
`define MCP_A_SPEED   6'h07
`define MCP_A_STATUS  6'h08
`define MCP_A_ERR_X   6'h09
`define MCP_A_ERR_Y   6'h0A

`define MCP_CFG_ABS   0
`define MCP_CMD_SEL_LO 4
`define MCP_RST_WORD  32'h0000_0000
`define MCP_RST_ERR   16'h0000

`define MCP_RESP_OK   2'h0
`define MCP_RESP_ERR  2'h2

`define MCP_E_MBUSY   16'h010F
`define MCP_E_SBUSY   16'h0110
`define MCP_E_MINH    16'h0111
`define MCP_E_SINH    16'h0112
`define MCP_E_MAUX    16'h0113
`define MCP_E_SAUX    16'h0114
`define MCP_E_MORG    16'h0115
`define MCP_E_SORG    16'h0116
`define MCP_E_PTEQ    16'h011C
`define MCP_E_SEEQ    16'h011D
`define MCP_E_RAD     16'h011E
`define MCP_E_LINE    16'h011F
`define MCP_E_ANG     16'h0122
`define MCP_E_SBUSYM  16'h0123
`define MCP_E_SINHM   16'h0124
`define MCP_E_SAUXM   16'h0125
`define MCP_E_NOMOVE  16'h0126
`define MCP_E_SEL     16'h0128
`define MCP_E_S2P_STP 16'h012D
`define MCP_E_S2P_SPD 16'h012E
`define MCP_E_S2P_SUB 16'h012F
`define MCP_E_S2P_ZER 16'h0130
`define MCP_E_P2S_STP 16'h0137
`define MCP_E_P2S_SUB 16'h0138

`endif

// ---- include/mcp_pkg.sv ----
/*
  Types of the motion command precheck: controller states, commands
  and arc modes. Assumes nothing of its surroundings.
*/
`default_nettype none
package mcp_pkg;
  typedef enum logic [1:0] {
    MCP_IDLE = 2'b00,
    MCP_WAIT = 2'b01,
    MCP_EVAL = 2'b10
  } mcp_state_t;
  typedef enum logic [2:0] {
    MCP_CMD_NONE   = 3'b000,
    MCP_CMD_CIRC   = 3'b001,
    MCP_CMD_SIMUL  = 3'b010,
    MCP_CMD_S2P    = 3'b011,
    MCP_CMD_P2S    = 3'b100,
    MCP_CMD_AUXCLR = 3'b101,
    MCP_CMD_FLOAT  = 3'b110
  } mcp_cmd_t;
  typedef enum logic [1:0] {
    MCP_ARC_CENTER = 2'b00,
    MCP_ARC_MIDDLE = 2'b01,
    MCP_ARC_RADIUS = 2'b10
  } mcp_arc_t;
endpackage
`default_nettype wire

// ---- src/mcp_collinear.sv ----
/*
  Registered collinearity test of three points by a cross product.
  Assumes operands steady for one cycle before the result is used.
*/
`timescale 1ns/1ps
`default_nettype none
module mcp_collinear (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] s_x,
  input  wire logic [31:0] s_y,
  input  wire logic [31:0] m_x,
  input  wire logic [31:0] m_y,
  input  wire logic [31:0] e_x,
  input  wire logic [31:0] e_y,
  output var  logic        line_q
);
  logic signed [32:0] d1x, d1y, d2x, d2y;
  logic signed [65:0] p1, p2;
  // One extra bit keeps the differences exact
  assign d1x = 33'(signed'(m_x)) - 33'(signed'(s_x));
  assign d1y = 33'(signed'(m_y)) - 33'(signed'(s_y));
  assign d2x = 33'(signed'(e_x)) - 33'(signed'(s_x));
  assign d2y = 33'(signed'(e_y)) - 33'(signed'(s_y));
  assign p1  = d1x * d2y;
  assign p2  = d1y * d2x;
  // Wide multipliers; registered to keep them off the decision path
  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_q <= 1'b0;
    end else begin
      line_q <= (p1 == p2);
    end
  end
endmodule // mcp_collinear
`default_nettype wire

// ---- src/mcp_flag.sv ----
/*
  Vector of sticky flags, each set by a pulse and cleared by a pulse.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mcp_flag #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output var  logic [W-1:0] flag_q
);
  // Set wins, so an event in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~clr) | set;
    end
  end
endmodule // mcp_flag
`default_nettype wire

// ---- src/mcp_precheck.sv ----
/*
  Motion command precheck for a two-axis positioner, with an AXI4-Lite
  register slave. Motion commands written to the command register while
  idle are checked against axis state and arc data, then either started or
  refused with an error code latched per axis; clear and origin commands skip the check.
  Assumes axis state inputs synchronous to clk; axis 0 is X, 1 is Y;
  for circular interpolation X is main and Y is subordinate.
*/
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`include "mcp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module mcp_precheck
  import mcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  axis_busy,
  input  wire logic [1:0]  out_inhibit,
  input  wire logic [1:0]  speed_ctrl,
  input  wire logic [1:0]  sync_sub,
  input  wire logic [1:0]  aux_code_on,
  input  wire logic [1:0]  homing_done,
  input  wire logic [31:0] cur_pos_x,
  input  wire logic [31:0] cur_pos_y,
  output var  logic        circ_go,
  output var  logic        simul_go,
  output var  logic        spd2pos_go,
  output var  logic        pos2spd_go,
  output var  logic [1:0]  cmd_axis,
  output var  logic        cmd_reject,
  output var  logic [1:0]  aux_code_clear_cmd
);
  logic [7:0]  aw_addr_q, ar_addr;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_en;
  logic [5:0]  wa;
  logic [31:0] rd_data;
  logic        rd_ok, wr_ok;
  logic [2:0]  cfg_q;
  logic [31:0] goal_x_q, goal_y_q, auxp_x_q, auxp_y_q, radius_q, speed_q;
  logic [5:0]  cmd_q;
  logic [15:0] err_x_q, err_y_q;
  logic        last_rej_q;
  mcp_state_t  state_q;
  logic [1:0]  aux_q, org_q, aux_clr, org_set;
  logic        line_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wa    = aw_addr_q[7:2];
  assign ar_addr = s_axi_araddr;
  assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_ok = (wa <= `MCP_A_ERR_Y) && (wa != `MCP_A_STATUS);

  // Address and data taken in either order; ready returns after response
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MCP_RESP_OK;
      aw_addr_q     <= 8'h00;
      w_data_q      <= `MCP_RST_WORD;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `MCP_RESP_OK : `MCP_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = `MCP_RST_WORD;
    case (ar_addr[7:2])
      `MCP_A_CMD:    rd_data = {26'h0, cmd_q};
      `MCP_A_CFG:    rd_data = {29'h0, cfg_q};
      `MCP_A_GOAL_X: rd_data = goal_x_q;
      `MCP_A_GOAL_Y: rd_data = goal_y_q;
      `MCP_A_AUXP_X: rd_data = auxp_x_q;
      `MCP_A_AUXP_Y: rd_data = auxp_y_q;
      `MCP_A_RADIUS: rd_data = radius_q;
      `MCP_A_SPEED:  rd_data = speed_q;
      `MCP_A_STATUS: rd_data = {26'h0, last_rej_q, state_q != MCP_IDLE, aux_q, org_q};
      `MCP_A_ERR_X:  rd_data = {16'h0, err_x_q};
      `MCP_A_ERR_Y:  rd_data = {16'h0, err_y_q};
      default:       rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `MCP_RST_WORD;
      s_axi_rresp   <= `MCP_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_ok ? `MCP_RESP_OK : `MCP_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Data registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q    <= 3'h0;
      goal_x_q <= `MCP_RST_WORD;
      goal_y_q <= `MCP_RST_WORD;
      auxp_x_q <= `MCP_RST_WORD;
      auxp_y_q <= `MCP_RST_WORD;
      radius_q <= `MCP_RST_WORD;
      speed_q  <= `MCP_RST_WORD;
    end else if (wr_en) begin
      case (wa)
        `MCP_A_CFG:    cfg_q    <= w_strb_q[0] ? w_data_q[2:0] : cfg_q;
        `MCP_A_GOAL_X: goal_x_q <= merge(goal_x_q, w_data_q, w_strb_q);
        `MCP_A_GOAL_Y: goal_y_q <= merge(goal_y_q, w_data_q, w_strb_q);
        `MCP_A_AUXP_X: auxp_x_q <= merge(auxp_x_q, w_data_q, w_strb_q);
        `MCP_A_AUXP_Y: auxp_y_q <= merge(auxp_y_q, w_data_q, w_strb_q);
        `MCP_A_RADIUS: radius_q <= merge(radius_q, w_data_q, w_strb_q);
        `MCP_A_SPEED:  speed_q  <= merge(speed_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // Check geometry and state
  logic        abs_m, cmd_wr;
  mcp_arc_t    arc;
  mcp_cmd_t    code;
  logic        ax;
  logic [1:0]  sel;
  logic [31:0] s_x, s_y;
  logic        a_eq_s, a_eq_e, s_eq_e;
  logic [33:0] ang_lim;
  logic [1:0]  nomove;
  logic [15:0] circ_e, sim_e0, sim_e1, sw_e;
  logic        circ_y;

  assign abs_m  = cfg_q[`MCP_CFG_ABS];
  assign arc    = mcp_arc_t'(cfg_q[2:1]);
  assign code   = mcp_cmd_t'(cmd_q[2:0]);
  assign sel    = cmd_q[`MCP_CMD_SEL_LO +: 2];
  assign ax     = sel[1];
  assign cmd_wr = wr_en && (wa == `MCP_A_CMD) && (state_q == MCP_IDLE);
  // Incremental points are offsets from a start at the origin
  assign s_x    = abs_m ? cur_pos_x : `MCP_RST_WORD;
  assign s_y    = abs_m ? cur_pos_y : `MCP_RST_WORD;
  assign a_eq_s = (auxp_x_q == s_x) && (auxp_y_q == s_y);
  assign a_eq_e = (auxp_x_q == goal_x_q) && (auxp_y_q == goal_y_q);
  assign s_eq_e = (s_x == goal_x_q) && (s_y == goal_y_q);
  // Quarter turn per step: speed above radius times 1.5703 (pi/2 less 0.03%)
  assign ang_lim = {2'b00, radius_q} + {3'b000, radius_q[31:1]}
                 + {6'h00, radius_q[31:4]} + {9'h000, radius_q[31:7]};
  assign nomove[0] = abs_m ? (goal_x_q == cur_pos_x) : (goal_x_q == `MCP_RST_WORD);
  assign nomove[1] = abs_m ? (goal_y_q == cur_pos_y) : (goal_y_q == `MCP_RST_WORD);

  mcp_collinear u_line (
    .clk    (clk),
    .nrst   (nrst),
    .s_x    (s_x),
    .s_y    (s_y),
    .m_x    (auxp_x_q),
    .m_y    (auxp_y_q),
    .e_x    (goal_x_q),
    .e_y    (goal_y_q),
    .line_q (line_q)
  );

  always_comb begin
    circ_y = 1'b0;
    circ_e = `MCP_RST_ERR;
    if (axis_busy[0]) begin
      circ_e = `MCP_E_MBUSY;
    end else if (axis_busy[1]) begin
      circ_e = `MCP_E_SBUSY;
      circ_y = 1'b1;
    end else if (out_inhibit[0]) begin
      circ_e = `MCP_E_MINH;
    end else if (out_inhibit[1]) begin
      circ_e = `MCP_E_SINH;
      circ_y = 1'b1;
    end else if (aux_q[0]) begin
      circ_e = `MCP_E_MAUX;
    end else if (aux_q[1]) begin
      circ_e = `MCP_E_SAUX;
      circ_y = 1'b1;
    end else if (abs_m && !org_q[0]) begin
      circ_e = `MCP_E_MORG;
    end else if (abs_m && !org_q[1]) begin
      circ_e = `MCP_E_SORG;
      circ_y = 1'b1;
    end else if (arc != MCP_ARC_RADIUS && (a_eq_s || a_eq_e)) begin
      circ_e = `MCP_E_PTEQ;
    end else if (arc == MCP_ARC_MIDDLE && s_eq_e) begin
      circ_e = `MCP_E_SEEQ;
    end else if (radius_q == `MCP_RST_WORD || radius_q[31]) begin
      circ_e = `MCP_E_RAD;
    end else if (arc == MCP_ARC_MIDDLE && line_q) begin
      circ_e = `MCP_E_LINE;
    end else if ({2'b00, speed_q} > ang_lim) begin
      circ_e = `MCP_E_ANG;
    end
  end

  function automatic logic [15:0] sim_chk(input logic busy, input logic inh,
                                          input logic aux, input logic nm);
    logic [15:0] e;
    e = `MCP_RST_ERR;
    if (busy) begin
      e = `MCP_E_SBUSYM;
    end else if (inh) begin
      e = `MCP_E_SINHM;
    end else if (aux) begin
      e = `MCP_E_SAUXM;
    end else if (nm) begin
      e = `MCP_E_NOMOVE;
    end
    return e;
  endfunction

  assign sim_e0 = sim_chk(axis_busy[0], out_inhibit[0], aux_q[0], nomove[0]);
  assign sim_e1 = sim_chk(axis_busy[1], out_inhibit[1], aux_q[1], nomove[1]);

  always_comb begin
    sw_e = `MCP_RST_ERR;
    if (code == MCP_CMD_S2P) begin
      if (!axis_busy[ax]) begin
        sw_e = `MCP_E_S2P_STP;
      end else if (!speed_ctrl[ax]) begin
        sw_e = `MCP_E_S2P_SPD;
      end else if (sync_sub[ax]) begin
        sw_e = `MCP_E_S2P_SUB;
      end else if ((ax ? goal_y_q : goal_x_q) == `MCP_RST_WORD) begin
        sw_e = `MCP_E_S2P_ZER;
      end
    end else begin
      if (!axis_busy[ax]) begin
        sw_e = `MCP_E_P2S_STP;
      end else if (sync_sub[ax]) begin
        sw_e = `MCP_E_P2S_SUB;
      end
    end
  end

  // Decision per command
  logic [15:0] ex, ey;
  logic        go;
  always_comb begin
    ex = `MCP_RST_ERR;
    ey = `MCP_RST_ERR;
    case (code)
      MCP_CMD_CIRC: begin
        if (circ_y) begin
          ey = circ_e;
        end else begin
          ex = circ_e;
        end
      end
      MCP_CMD_SIMUL: begin
        if (sel != 2'b11) begin
          ex = `MCP_E_SEL;
        end else begin
          ex = sim_e0;
          ey = sim_e1;
        end
      end
      MCP_CMD_S2P, MCP_CMD_P2S: begin
        if (ax) begin
          ey = sw_e;
        end else begin
          ex = sw_e;
        end
      end
      default: ;
    endcase
  end
  assign go = (ex == `MCP_RST_ERR) && (ey == `MCP_RST_ERR);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= MCP_IDLE;
      cmd_q   <= 6'h00;
    end else begin
      case (state_q)
        MCP_IDLE: begin
          if (cmd_wr) begin
            cmd_q <= w_data_q[5:0];
            // Clear and origin commands need no check
            if (w_data_q[2:0] == MCP_CMD_AUXCLR || w_data_q[2:0] == MCP_CMD_FLOAT) begin
              state_q <= MCP_IDLE;
            end else begin
              state_q <= MCP_WAIT;
            end
          end
        end
        MCP_WAIT: state_q <= MCP_EVAL;
        MCP_EVAL: state_q <= MCP_IDLE;
        default:  state_q <= MCP_IDLE;
      endcase
    end
  end

  // Per-axis flag selects: bit0 X, bit1 Y
  assign aux_clr = (cmd_wr && w_data_q[2:0] == MCP_CMD_AUXCLR) ?
                   w_data_q[`MCP_CMD_SEL_LO +: 2] : 2'b00;
  assign org_set = homing_done |
                   ((cmd_wr && w_data_q[2:0] == MCP_CMD_FLOAT) ?
                    w_data_q[`MCP_CMD_SEL_LO +: 2] : 2'b00);

  mcp_flag #(.W(2)) u_aux (
    .clk    (clk),
    .nrst   (nrst),
    .set    (aux_code_on),
    .clr    (aux_clr),
    .flag_q (aux_q)
  );

  // No path unsettles an origin except reset
  mcp_flag #(.W(2)) u_org (
    .clk    (clk),
    .nrst   (nrst),
    .set    (org_set),
    .clr    (2'b00),
    .flag_q (org_q)
  );

  // Starts only when clean; refusal pulses cmd_reject and sets last_rej_q beside the error words
  always_ff @(posedge clk) begin
    if (!nrst) begin
      circ_go    <= 1'b0;
      simul_go   <= 1'b0;
      spd2pos_go <= 1'b0;
      pos2spd_go <= 1'b0;
      cmd_reject <= 1'b0;
      cmd_axis   <= 2'b00;
      last_rej_q <= 1'b0;
      aux_code_clear_cmd <= 2'b00;
    end else begin
      aux_code_clear_cmd <= aux_clr;
      circ_go    <= 1'b0;
      simul_go   <= 1'b0;
      spd2pos_go <= 1'b0;
      pos2spd_go <= 1'b0;
      cmd_reject <= 1'b0;
      if (state_q == MCP_EVAL) begin
        circ_go    <= go && code == MCP_CMD_CIRC;
        simul_go   <= go && code == MCP_CMD_SIMUL;
        spd2pos_go <= go && code == MCP_CMD_S2P;
        pos2spd_go <= go && code == MCP_CMD_P2S;
        cmd_reject <= !go;
        last_rej_q <= !go;
        cmd_axis   <= sel;
      end
    end
  end

  // Latch on refusal wins over a clearing write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      err_x_q <= `MCP_RST_ERR;
      err_y_q <= `MCP_RST_ERR;
    end else begin
      if (state_q == MCP_EVAL && ex != `MCP_RST_ERR) begin
        err_x_q <= ex;
      end else if (wr_en && wa == `MCP_A_ERR_X) begin
        err_x_q <= `MCP_RST_ERR;
      end
      if (state_q == MCP_EVAL && ey != `MCP_RST_ERR) begin
        err_y_q <= ey;
      end else if (wr_en && wa == `MCP_A_ERR_Y) begin
        err_y_q <= `MCP_RST_ERR;
      end
    end
  end
endmodule // mcp_precheck
`default_nettype wire
